// file: logic/typec_status_pkg.sv
`default_nettype none
package typec_status_pkg;
    // Register offsets
    localparam logic [7:0] RES_FLAGS_ADDR = 8'h06;
    localparam logic [7:0] COMMON_ADDR = 8'h07;
    localparam logic [7:0] VCONN_ADDR = 8'h08;
    localparam logic [7:0] STATE_ADDR = 8'h09;
    localparam logic [7:0] CONTROL_ADDR = 8'h10;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Resistive flag positions
    localparam int GROUND_BIT = 5;
    localparam int SIDEBAND_BIT = 4;
    localparam int FINITE_BIT = 3;
    localparam int OPEN_BIT = 2;
    localparam int ABORT_BIT = 1;
    localparam int MOIST_BIT = 0;
    localparam int RES_FLAG_COUNT = 6;
    // Common status positions
    localparam int FAULT_BIT = 7;
    localparam int BAT_OV_BIT = 6;
    localparam int BAT_UV_BIT = 5;
    localparam int THERMAL_BIT = 4;
    localparam int LOW_POWER_BIT = 3;
    localparam int SAFE_ZERO_BIT = 1;
    localparam int IN_RANGE_BIT = 0;
    // Cable power status positions
    localparam int SHORT_BIT = 3;
    localparam int ENABLED_BIT = 2;
    localparam int OVERCURRENT_BIT = 1;
    localparam int GATED_BIT = 0;
    // CC machine status fields
    localparam int RESULT_LSB = 4;
    localparam int PIN_LSB = 2;
    localparam int CURRENT_LSB = 0;
    // Control register positions
    localparam int RELEASE_BIT = 0;
    localparam int MANUAL_BIT = 1;
    // Synchronised analog levels
    localparam int PIN_COUNT = 8;
    localparam int PIN_BAT_OV = 0;
    localparam int PIN_BAT_UV = 1;
    localparam int PIN_THERMAL = 2;
    localparam int PIN_SAFE_ZERO = 3;
    localparam int PIN_BUS_DET = 4;
    localparam int PIN_BUS_OVLO = 5;
    localparam int PIN_SHORT = 6;
    localparam int PIN_OVERCURRENT = 7;
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_FAULT = 2'b10
    } fault_state_t;
endpackage : typec_status_pkg
`default_nettype wire

// file: logic/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            // Level moves only once the last two stages agree
            always_ff @(posedge clk_sys)
            begin
                if (sys_rst)
                begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                    stage3[i] <= 1'b0;
                    level[i] <= 1'b0;
                end
                else if (ce)
                begin
                    stage1[i] <= pin_in[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    if (stage2[i] == stage3[i])
                    begin
                        level[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule : pin_sync
`default_nettype wire

// file: logic/event_flags.sv
`timescale 1ns/1ns
`default_nettype none
module event_flags #(
    parameter int WIDTH = 6
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] set_evt,
    input wire logic [WIDTH-1:0] clear_req,
    output logic [WIDTH-1:0] flags
);
    logic [WIDTH-1:0] next_flags;

    // Set beats clear in the same cycle
    assign next_flags = (flags & ~clear_req) | set_evt;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            flags <= '0;
        end
        else if (ce)
        begin
            flags <= next_flags;
        end
    end
endmodule : event_flags
`default_nettype wire

// file: logic/typec_charger_status_regs.sv
`timescale 1ns/1ns
`default_nettype none
module typec_charger_status_regs #(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic meas_ground_evt,
    input wire logic meas_sideband_done_evt,
    input wire logic meas_finite_invalid_evt,
    input wire logic meas_open_evt,
    input wire logic meas_abort_evt,
    input wire logic meas_moisture_evt,
    input wire logic bat_over_pin,
    input wire logic bat_under_pin,
    input wire logic thermal_pin,
    input wire logic bus_safe_zero_pin,
    input wire logic bus_detect_pin,
    input wire logic bus_over_pin,
    input wire logic cable_short_pin,
    input wire logic cable_overcurrent_pin,
    input wire logic low_power_entered,
    input wire logic cable_power_enabled,
    input wire logic charger_detect_gated,
    input wire logic [2:0] cc_machine_result,
    input wire logic [1:0] active_cc_pin,
    input wire logic [1:0] sink_current_allowed,
    output logic fault_state,
    output logic charger_detect_run
);
    logic [typec_status_pkg::PIN_COUNT-1:0] pins_raw;
    logic [typec_status_pkg::PIN_COUNT-1:0] pins;
    logic [typec_status_pkg::RES_FLAG_COUNT-1:0] meas_evt;
    logic [typec_status_pkg::RES_FLAG_COUNT-1:0] flag_clear;
    logic [typec_status_pkg::RES_FLAG_COUNT-1:0] res_flags;
    typec_status_pkg::fault_state_t state;
    typec_status_pkg::fault_state_t next_state;
    logic charger_detect_manual_run;
    logic next_detect_run;

    // Analog comparator levels cross into the clock domain
    assign pins_raw = {
        cable_overcurrent_pin,
        cable_short_pin,
        bus_over_pin,
        bus_detect_pin,
        bus_safe_zero_pin,
        thermal_pin,
        bat_under_pin,
        bat_over_pin
    };

    pin_sync #(
        .WIDTH(typec_status_pkg::PIN_COUNT)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .pin_in(pins_raw),
        .level(pins)
    );

    logic battery_over_voltage;
    logic battery_under_voltage;
    logic thermal_fault_active;
    logic bus_above_safe_zero;
    logic bus_supply_in_range;
    logic cable_power_short;
    logic cable_power_overcurrent;

    assign battery_over_voltage = pins[typec_status_pkg::PIN_BAT_OV];
    assign battery_under_voltage = pins[typec_status_pkg::PIN_BAT_UV];
    assign thermal_fault_active = pins[typec_status_pkg::PIN_THERMAL];
    assign bus_above_safe_zero = pins[typec_status_pkg::PIN_SAFE_ZERO];
    assign bus_supply_in_range = pins[typec_status_pkg::PIN_BUS_DET]
        & ~pins[typec_status_pkg::PIN_BUS_OVLO];
    assign cable_power_short = pins[typec_status_pkg::PIN_SHORT];
    assign cable_power_overcurrent = pins[typec_status_pkg::PIN_OVERCURRENT];

    // Register port decode
    logic sel_flags;
    logic sel_common;
    logic sel_vconn;
    logic sel_state;
    logic sel_control;
    logic wr_flags;
    logic wr_control;
    logic fault_release;

    assign sel_flags = reg_addr == typec_status_pkg::RES_FLAGS_ADDR;
    assign sel_common = reg_addr == typec_status_pkg::COMMON_ADDR;
    assign sel_vconn = reg_addr == typec_status_pkg::VCONN_ADDR;
    assign sel_state = reg_addr == typec_status_pkg::STATE_ADDR;
    assign sel_control = reg_addr == typec_status_pkg::CONTROL_ADDR;
    assign wr_flags = ce & reg_wr & sel_flags;
    assign wr_control = ce & reg_wr & sel_control;
    assign fault_release = wr_control & reg_wdata[typec_status_pkg::RELEASE_BIT];

    // Resistive measurement flags, write one to clear
    assign meas_evt = {
        meas_ground_evt,
        meas_finite_invalid_evt == 1'b1 ? 1'b0 : 1'b0,
        1'b0,
        1'b0,
        1'b0,
        1'b0
    } | {
        1'b0,
        meas_sideband_done_evt,
        meas_finite_invalid_evt,
        meas_open_evt,
        meas_abort_evt,
        meas_moisture_evt
    };
    assign flag_clear = wr_flags
        ? reg_wdata[typec_status_pkg::RES_FLAG_COUNT-1:0]
        : '0;

    event_flags #(
        .WIDTH(typec_status_pkg::RES_FLAG_COUNT)
    ) u_event_flags (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .set_evt(meas_evt),
        .clear_req(flag_clear),
        .flags(res_flags)
    );

    // Fault state machine
    logic fault_cause;

    assign fault_cause = battery_over_voltage | thermal_fault_active;

    always_comb
    begin
        case (state)
            typec_status_pkg::ST_RUN:
            begin
                next_state = fault_cause
                    ? typec_status_pkg::ST_FAULT
                    : typec_status_pkg::ST_RUN;
            end
            typec_status_pkg::ST_FAULT:
            begin
                next_state = (fault_release & ~fault_cause)
                    ? typec_status_pkg::ST_RUN
                    : typec_status_pkg::ST_FAULT;
            end
            default:
            begin
                next_state = typec_status_pkg::ST_FAULT;
            end
        endcase
    end

    // Gated detection may still be started by hand
    assign next_detect_run = ~charger_detect_gated | charger_detect_manual_run;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state <= typec_status_pkg::ST_RUN;
            fault_state <= 1'b0;
            charger_detect_manual_run <= 1'b0;
            charger_detect_run <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            fault_state <= next_state == typec_status_pkg::ST_FAULT;
            charger_detect_run <= next_detect_run;
            if (wr_control)
            begin
                charger_detect_manual_run <= reg_wdata[typec_status_pkg::MANUAL_BIT];
            end
        end
    end

    // Register images
    logic [7:0] common_status;
    logic [7:0] cc_status_vconn;
    logic [7:0] cc_status_state;
    logic [7:0] control_image;
    logic [7:0] next_rdata;

    assign common_status = {
        state == typec_status_pkg::ST_FAULT,
        battery_over_voltage,
        battery_under_voltage,
        thermal_fault_active,
        low_power_entered,
        1'b0,
        bus_above_safe_zero,
        bus_supply_in_range
    };
    assign cc_status_vconn = {
        4'h0,
        cable_power_short,
        cable_power_enabled,
        cable_power_overcurrent,
        charger_detect_gated
    };
    assign cc_status_state = {
        1'b0,
        cc_machine_result,
        active_cc_pin,
        sink_current_allowed
    };
    assign control_image = {6'h00, charger_detect_manual_run, 1'b0};
    assign next_rdata = sel_flags ? {2'h0, res_flags}
        : sel_common ? common_status
        : sel_vconn ? cc_status_vconn
        : sel_state ? cc_status_state
        : sel_control ? control_image
        : typec_status_pkg::STATUS_RESET;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            reg_rdata <= typec_status_pkg::STATUS_RESET;
            reg_rvalid <= 1'b0;
        end
        else if (ce)
        begin
            reg_rdata <= reg_rd ? next_rdata : reg_rdata;
            reg_rvalid <= reg_rd;
        end
    end

    ground_flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && meas_ground_evt |=> res_flags[typec_status_pkg::GROUND_BIT])
        else $error("ground flag not set");
    sideband_flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && meas_sideband_done_evt |=> res_flags[typec_status_pkg::SIDEBAND_BIT])
        else $error("sideband flag not set");
    finite_flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && meas_finite_invalid_evt |=> res_flags[typec_status_pkg::FINITE_BIT])
        else $error("finite flag not set");
    open_flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && meas_open_evt |=> res_flags[typec_status_pkg::OPEN_BIT])
        else $error("open flag not set");
    abort_flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && meas_abort_evt |=> res_flags[typec_status_pkg::ABORT_BIT])
        else $error("abort flag not set");
    moisture_flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && meas_moisture_evt |=> res_flags[typec_status_pkg::MOIST_BIT])
        else $error("moisture flag not set");
    flag_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        res_flags[typec_status_pkg::GROUND_BIT] && !wr_flags |=>
        res_flags[typec_status_pkg::GROUND_BIT])
        else $error("flag dropped without clear");
    fault_entry_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && fault_cause |=> fault_state && state == typec_status_pkg::ST_FAULT)
        else $error("fault not entered");
    fault_exit_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        fault_state && !fault_release |=> fault_state)
        else $error("fault left without release");
    in_range_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && reg_rd && sel_common |=> reg_rvalid
        && reg_rdata[typec_status_pkg::IN_RANGE_BIT] == $past(bus_supply_in_range))
        else $error("bus range bit wrong");
    result_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && reg_rd && sel_state |=> reg_rdata[6:4] == $past(cc_machine_result)
        && reg_rdata[7] == 1'b0)
        else $error("cc result field wrong");
    gated_run_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ce && charger_detect_gated && !charger_detect_manual_run |=> !charger_detect_run)
        else $error("detection ran while gated");
endmodule : typec_charger_status_regs
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk_sys;
    logic sys_rst;
    logic ce;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [5:0] evt;
    logic [7:0] pins;
    logic low_power_entered;
    logic cable_power_enabled;
    logic charger_detect_gated;
    logic [2:0] cc_machine_result;
    logic [1:0] active_cc_pin;
    logic [1:0] sink_current_allowed;
    logic fault_state;
    logic charger_detect_run;
    logic [7:0] expect_q[$];
    logic [31:0] rng;
    logic [7:0] pin_tab[6] = '{8'h02, 8'h08, 8'h10, 8'h30, 8'h40, 8'h80};
    logic [7:0] adr_tab[6] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h08, 8'h08};
    logic [7:0] exp_tab[6] = '{8'h20, 8'h02, 8'h01, 8'h00, 8'h08, 8'h02};
    int fails;
    int samples_checked;

    typec_charger_status_regs i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .meas_ground_evt(evt[5]), .meas_sideband_done_evt(evt[4]),
        .meas_finite_invalid_evt(evt[3]), .meas_open_evt(evt[2]),
        .meas_abort_evt(evt[1]), .meas_moisture_evt(evt[0]),
        .bat_over_pin(pins[0]), .bat_under_pin(pins[1]), .thermal_pin(pins[2]),
        .bus_safe_zero_pin(pins[3]), .bus_detect_pin(pins[4]), .bus_over_pin(pins[5]),
        .cable_short_pin(pins[6]), .cable_overcurrent_pin(pins[7]),
        .low_power_entered(low_power_entered), .cable_power_enabled(cable_power_enabled),
        .charger_detect_gated(charger_detect_gated), .cc_machine_result(cc_machine_result),
        .active_cc_pin(active_cc_pin), .sink_current_allowed(sink_current_allowed),
        .fault_state(fault_state), .charger_detect_run(charger_detect_run)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare_byte

    task automatic compare_level(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compare_level

    task automatic final_report;
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expect_q.push_back(e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic pulse(input logic [5:0] m);
        @(posedge clk_sys);
        evt <= m;
        @(posedge clk_sys);
        evt <= 6'h00;
    endtask : pulse

    // Pins pass three sync stages and an agree stage
    task automatic set_pins(input logic [7:0] v);
        @(posedge clk_sys);
        pins <= v;
        repeat (6) @(posedge clk_sys);
    endtask : set_pins

    // Read data checker, oldest note first
    always @(posedge clk_sys)
    begin
        if (reg_rvalid === 1'b1)
        begin
            if (expect_q.size() == 0)
            begin
                fails++;
                $display("[ERR] t=%0t got=%h exp=none", $time, reg_rdata);
            end
            else
                compare_byte(reg_rdata, expect_q.pop_front());
        end
    end

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        final_report();
    end

    initial
    begin
        logic [7:0] m;
        logic [1:0] p;
        logic [1:0] c;
        fails = 0;
        samples_checked = 0;
        rng = 32'h0000_B0A0;
        sys_rst = 1'b1;
        ce = 1'b1;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        evt = 6'h00;
        pins = 8'h00;
        low_power_entered = 1'b0;
        cable_power_enabled = 1'b0;
        charger_detect_gated = 1'b0;
        cc_machine_result = 3'h0;
        active_cc_pin = 2'h0;
        sink_current_allowed = 2'h0;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        for (int a = 6; a < 10; a++)
            rd(8'(a), 8'h00);
        rd(8'h0F, 8'h00);
        compare_level(fault_state, 1'b0);
        compare_level(charger_detect_run, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            m = 8'h01 << i;
            pulse(m[5:0]);
            rd(8'h06, m);
            rd(8'h06, m);
            wr(8'h06, m);
            rd(8'h06, 8'h00);
        end
        for (int k = 0; k < 4; k++)
        begin
            m = {2'b00, rng[5:0]};
            rng = xs(rng);
            pulse(m[5:0]);
            rd(8'h06, m);
            wr(8'h06, 8'hC0 | (m & 8'h15));
            rd(8'h06, m & 8'h2A);
            wr(8'h06, 8'h3F);
        end
        @(posedge clk_sys);
        evt <= 6'h20;
        reg_addr <= 8'h06;
        reg_wdata <= 8'h3F;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        evt <= 6'h00;
        reg_wr <= 1'b0;
        rd(8'h06, 8'h20);
        wr(8'h06, 8'h20);
        // Clock enable low: event must be ignored
        ce <= 1'b0;
        pulse(6'h01);
        ce <= 1'b1;
        rd(8'h06, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            set_pins(pin_tab[i]);
            rd(adr_tab[i], exp_tab[i]);
        end
        set_pins(8'h00);
        low_power_entered <= 1'b1;
        rd(8'h07, 8'h08);
        low_power_entered <= 1'b0;
        set_pins(8'h01);
        rd(8'h07, 8'hC0);
        compare_level(fault_state, 1'b1);
        wr(8'h10, 8'h01);
        rd(8'h07, 8'hC0);
        set_pins(8'h00);
        rd(8'h07, 8'h80);
        wr(8'h10, 8'h01);
        rd(8'h07, 8'h00);
        compare_level(fault_state, 1'b0);
        set_pins(8'h04);
        rd(8'h07, 8'h90);
        set_pins(8'h00);
        wr(8'h10, 8'h01);
        rd(8'h07, 8'h00);
        cable_power_enabled <= 1'b1;
        charger_detect_gated <= 1'b1;
        rd(8'h08, 8'h05);
        compare_level(charger_detect_run, 1'b0);
        wr(8'h10, 8'h02);
        repeat (2) @(posedge clk_sys);
        compare_level(charger_detect_run, 1'b1);
        rd(8'h10, 8'h02);
        wr(8'h10, 8'h00);
        cable_power_enabled <= 1'b0;
        rd(8'h08, 8'h01);
        charger_detect_gated <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            p = rng[1:0];
            c = rng[3:2];
            rng = xs(rng);
            cc_machine_result <= 3'(i);
            active_cc_pin <= p;
            sink_current_allowed <= c;
            rd(8'h09, {1'b0, 3'(i), p, c});
        end
        for (int w = 0; w < 20 && expect_q.size() > 0; w++)
            @(posedge clk_sys);
        if (expect_q.size() > 0)
            fails++;
        final_report();
    end
endmodule : testbench
`default_nettype wire
